// File: src/cra_core.v
// Purpose: Register set and effective address unit of a 16-bit core
// Assumes: Memory answers each byte read with MEM_ACK, any latency
// Notes:   Software feeds program bytes through the queue register
// Contract
// - Two 8-bit accumulators, also seen joined as a 16-bit double one.
// - Indexed address is index register plus 5, 9, 16-bit or accumulator.
// - Stack pointer marks last used slot and serves every indexed form.
// - Program counter holds next instruction; indexed base except auto forms.
// - Condition codes hold five flags, two interrupt masks, stop disable.
// - Half carry only for decimal adjust; branches test N, Z, V, C.
// - Reset fetches start vector and sets both interrupt masks.
// - Reset sets stop disable; stop is inhibited while it is set.
// - Words are big-endian over two consecutive byte addresses.
// - No alignment required for bytes, words or instructions.
// - Queue gives the decoder at least three bytes per instruction.
// - Direct mode addresses only the first 256-byte page.
// - Relative mode adds 8 or 16-bit offset to program counter.
// - Shortest indexed form adds signed 5-bit constant, no extension.
// - Auto pre/post step of 1 to 8 on X, Y or SP, never PC.
// - Accumulator offset adds unsigned A, B, or D to the base.
// - Nine-bit offset: low byte from extension, sign from postbyte.
// - Sixteen-bit constant offset read from two extension bytes.
// - Sixteen-bit indirect reads pointer at base plus offset.
// - Double accumulator indirect reads pointer at base plus D.
// - Immediate operand from stream, width set by the instruction.
// - Inherent operands only in registers; registers not memory mapped.
// - Opcodes are 8 bits; a fixed prefix byte selects page two.
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
`include "cra_defs.vh"
module cra_core #(
  parameter [15:0] RESET_VEC = `CRA_VEC_ADDR,
  parameter [7:0]  STOP_OPC  = `CRA_STOP_OPC,
  parameter        QDEPTH    = 8,
  parameter        QAW       = 3
) (
  input  wire        CLK_SYS,
  input  wire        RST,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  output reg  [15:0] MEM_ADDR,
  output reg         MEM_RD,
  input  wire [7:0]  MEM_RDATA,
  input  wire        MEM_ACK,
  output reg         STOP_REQ,
  output reg         BUSY
);
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_POP   = 3'h1;
  localparam [2:0] ST_TAKE  = 3'h2;
  localparam [2:0] ST_EXEC  = 3'h3;
  localparam [2:0] ST_MREQ  = 3'h4;
  localparam [2:0] ST_MWAIT = 3'h5;

  // Wrapping 16-bit add, carry dropped
  function [15:0] add16;
    input [15:0] a;
    input [15:0] b;
    begin
      add16 = a + b;
    end
  endfunction

  function [15:0] sext8;
    input [7:0] v;
    begin
      sext8 = {{8{v[7]}}, v};
    end
  endfunction

  // Extension bytes that follow an indexed postbyte
  function [1:0] idx_ext;
    input [7:0] pb;
    begin
      if (pb[7:5] != 3'h7 || pb[2]) begin
        idx_ext = 2'h0;
      end else if (!pb[1]) begin
        idx_ext = 2'h1;
      end else begin
        idx_ext = 2'h2;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State
  reg [7:0]  acc_a_r;
  reg [7:0]  acc_b_r;
  reg [15:0] ix_r;
  reg [15:0] iy_r;
  reg [15:0] sp_r;
  reg [15:0] pc_r;
  reg [7:0]  ccr_r;
  reg [2:0]  mode_r;
  reg        imm16_r;
  reg [2:0]  cond_r;
  reg        go_r;
  reg [2:0]  state_r;
  reg        page2_r;
  reg        nb_r;
  reg        got_pb_r;
  reg [1:0]  rem_r;
  reg [3:0]  len_r;
  reg [7:0]  opc_r;
  reg [7:0]  pb_r;
  reg [15:0] ext_r;
  reg [15:0] ea_r;
  reg [15:0] opnd_r;
  reg        taken_r;
  reg        stop_blk_r;
  reg        vec_r;
  reg        bsel_r;
  reg [15:0] mptr_r;
  reg [7:0]  mhi_r;
  reg        ahb_wr_r;
  reg        ahb_rd_r;
  reg [7:0]  ahb_a_r;

  wire [7:0]     q_rd;
  wire [QAW:0]   q_cnt;
  wire           q_pop = (state_r == ST_POP);
  wire           idle  = (state_r == ST_IDLE) && !go_r;
  wire           q_push = ahb_wr_r && (ahb_a_r == `CRA_OFF_QDATA) &&
                          (q_cnt != QDEPTH[QAW:0]);
  wire [15:0]    acc_d = {acc_a_r, acc_b_r};

  // Program bytes buffered ahead of the decoder
  cra_queue #(.WIDTH(8), .DEPTH(QDEPTH), .AW(QAW)) u_queue (
    .clk     (CLK_SYS),
    .rst     (RST),
    .wr_en   (q_push),
    .wr_data (HWDATA[7:0]),
    .rd_en   (q_pop),
    .rd_data (q_rd),
    .count   (q_cnt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address formation
  reg [1:0]  rr;
  reg [15:0] npc;
  reg [15:0] base;
  reg [15:0] step;
  reg [15:0] ea_nxt;
  reg [15:0] wb_nxt;
  reg        wb_en;
  reg        ind;
  reg        cond_ok;

  always @* begin
    rr     = (pb_r[7:5] == 3'h7) ? pb_r[4:3] : pb_r[7:6];
    npc    = add16(pc_r, {12'h000, len_r});
    ea_nxt = 16'h0000;
    wb_nxt = 16'h0000;
    wb_en  = 1'b0;
    ind    = 1'b0;
    step   = pb_r[3] ? {12'hFFF, pb_r[3:0]}
                     : add16({12'h000, pb_r[3:0]}, 16'h0001);
    case (rr)
      2'h0: base = ix_r;
      2'h1: base = iy_r;
      2'h2: base = sp_r;
      default: base = npc;
    endcase
    case (cond_r)
      3'h1: cond_ok = ccr_r[`CRA_CCR_Z];
      3'h2: cond_ok = !ccr_r[`CRA_CCR_Z];
      3'h3: cond_ok = ccr_r[`CRA_CCR_N];
      3'h4: cond_ok = ccr_r[`CRA_CCR_C];
      3'h5: cond_ok = ccr_r[`CRA_CCR_V];
      3'h6: cond_ok = ccr_r[`CRA_CCR_N] ^ ccr_r[`CRA_CCR_V];
      default: cond_ok = 1'b1;
    endcase
    case (mode_r)
      `CRA_MODE_DIR: ea_nxt = {8'h00, ext_r[7:0]};
      `CRA_MODE_EXT: ea_nxt = ext_r;
      `CRA_MODE_REL8: ea_nxt = add16(npc, sext8(ext_r[7:0]));
      `CRA_MODE_REL16: ea_nxt = add16(npc, ext_r);
      `CRA_MODE_IDX: begin
        if (pb_r[7:5] != 3'h7 && !pb_r[5]) begin
          ea_nxt = add16(base, {{11{pb_r[4]}}, pb_r[4:0]});
        end else if (pb_r[7:5] != 3'h7) begin
          // Top postbyte codes leave PC out of the auto forms
          wb_nxt = add16(base, step);
          wb_en  = 1'b1;
          ea_nxt = pb_r[4] ? base : wb_nxt;
        end else if (!pb_r[2] && !pb_r[1]) begin
          ea_nxt = add16(base, {{8{pb_r[0]}}, ext_r[7:0]});
        end else if (!pb_r[2]) begin
          ea_nxt = add16(base, ext_r);
          ind    = pb_r[0];
        end else begin
          case (pb_r[1:0])
            2'h0: ea_nxt = add16(base, {8'h00, acc_a_r});
            2'h1: ea_nxt = add16(base, {8'h00, acc_b_r});
            default: ea_nxt = add16(base, acc_d);
          endcase
          ind = (pb_r[1:0] == 2'h3);
        end
      end
      default: ea_nxt = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode sequencer and register file
  always @(posedge CLK_SYS) begin
    if (RST) begin
      acc_a_r    <= 8'h00;
      acc_b_r    <= 8'h00;
      ix_r       <= 16'h0000;
      iy_r       <= 16'h0000;
      sp_r       <= 16'h0000;
      pc_r       <= 16'h0000;
      ccr_r      <= `CRA_CCR_RST;
      mode_r     <= `CRA_MODE_INH;
      imm16_r    <= 1'b0;
      cond_r     <= 3'h0;
      go_r       <= 1'b0;
      state_r    <= ST_MREQ;
      vec_r      <= 1'b1;
      mptr_r     <= RESET_VEC;
      bsel_r     <= 1'b0;
      mhi_r      <= 8'h00;
      page2_r    <= 1'b0;
      nb_r       <= 1'b0;
      got_pb_r   <= 1'b0;
      rem_r      <= 2'h0;
      len_r      <= 4'h0;
      opc_r      <= 8'h00;
      pb_r       <= 8'h00;
      ext_r      <= 16'h0000;
      ea_r       <= 16'h0000;
      opnd_r     <= 16'h0000;
      taken_r    <= 1'b0;
      stop_blk_r <= 1'b0;
      MEM_ADDR   <= 16'h0000;
      MEM_RD     <= 1'b0;
      STOP_REQ   <= 1'b0;
      BUSY       <= 1'b1;
    end else begin
      MEM_RD   <= 1'b0;
      STOP_REQ <= 1'b0;
      BUSY     <= !(state_r == ST_IDLE && !go_r);
      // Registers only writable between instructions; keeps
      // them off the memory port entirely
      if (ahb_wr_r && idle) begin
        case (ahb_a_r)
          `CRA_OFF_ACCA: acc_a_r <= HWDATA[7:0];
          `CRA_OFF_ACCB: acc_b_r <= HWDATA[7:0];
          `CRA_OFF_ACCD: {acc_a_r, acc_b_r} <= HWDATA[15:0];
          `CRA_OFF_IX:   ix_r <= HWDATA[15:0];
          `CRA_OFF_IY:   iy_r <= HWDATA[15:0];
          `CRA_OFF_SP:   sp_r <= HWDATA[15:0];
          `CRA_OFF_PC:   pc_r <= HWDATA[15:0];
          `CRA_OFF_CCR:  ccr_r <= HWDATA[7:0];
          `CRA_OFF_CTRL: begin
            mode_r  <= HWDATA[2:0];
            imm16_r <= HWDATA[`CRA_CTRL_IMM16];
            cond_r  <= HWDATA[6:4];
            go_r    <= HWDATA[`CRA_CTRL_GO];
          end
          default: ;
        endcase
      end
      case (state_r)
        ST_IDLE: begin
          if (go_r && q_cnt >= `CRA_MIN_QUEUE) begin
            go_r     <= 1'b0;
            page2_r  <= 1'b0;
            nb_r     <= 1'b0;
            got_pb_r <= 1'b0;
            len_r    <= 4'h0;
            ext_r    <= 16'h0000;
            pb_r     <= 8'h00;
            state_r  <= ST_POP;
          end
        end
        ST_POP: state_r <= ST_TAKE;
        ST_TAKE: begin
          len_r   <= len_r + 4'h1;
          state_r <= ST_POP;
          if (!nb_r) begin
            if (q_rd == `CRA_PAGE2_PFX && !page2_r) begin
              page2_r <= 1'b1;
            end else begin
              opc_r <= q_rd;
              nb_r  <= 1'b1;
              case (mode_r)
                `CRA_MODE_IMM: rem_r <= imm16_r ? 2'h2 : 2'h1;
                `CRA_MODE_EXT,
                `CRA_MODE_REL16: rem_r <= 2'h2;
                `CRA_MODE_DIR,
                `CRA_MODE_REL8,
                `CRA_MODE_IDX: rem_r <= 2'h1;
                default: begin
                  rem_r   <= 2'h0;
                  state_r <= ST_EXEC;
                end
              endcase
            end
          end else if (mode_r == `CRA_MODE_IDX && !got_pb_r) begin
            pb_r     <= q_rd;
            got_pb_r <= 1'b1;
            rem_r    <= idx_ext(q_rd);
            if (idx_ext(q_rd) == 2'h0) begin
              state_r <= ST_EXEC;
            end
          end else begin
            ext_r <= {ext_r[7:0], q_rd};
            rem_r <= rem_r - 2'h1;
            if (rem_r == 2'h1) begin
              state_r <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          pc_r    <= npc;
          ea_r    <= ea_nxt;
          taken_r <= 1'b0;
          opnd_r  <= imm16_r ? ext_r : {8'h00, ext_r[7:0]};
          state_r <= ST_IDLE;
          if ((mode_r == `CRA_MODE_REL8 || mode_r == `CRA_MODE_REL16) &&
              cond_ok) begin
            pc_r    <= ea_nxt;
            taken_r <= 1'b1;
          end
          if (wb_en) begin
            case (rr)
              2'h0: ix_r <= wb_nxt;
              2'h1: iy_r <= wb_nxt;
              default: sp_r <= wb_nxt;
            endcase
          end
          if (mode_r == `CRA_MODE_INH && page2_r && opc_r == STOP_OPC) begin
            STOP_REQ   <= !ccr_r[`CRA_CCR_S];
            stop_blk_r <= ccr_r[`CRA_CCR_S];
          end else begin
            stop_blk_r <= 1'b0;
          end
          if (ind) begin
            mptr_r  <= ea_nxt;
            vec_r   <= 1'b0;
            bsel_r  <= 1'b0;
            state_r <= ST_MREQ;
          end
        end
        ST_MREQ: begin
          MEM_RD   <= 1'b1;
          MEM_ADDR <= add16(mptr_r, {15'h0000, bsel_r});
          state_r  <= ST_MWAIT;
        end
        ST_MWAIT: begin
          if (MEM_ACK) begin
            if (!bsel_r) begin
              mhi_r   <= MEM_RDATA;
              bsel_r  <= 1'b1;
              state_r <= ST_MREQ;
            end else begin
              if (vec_r) begin
                pc_r <= {mhi_r, MEM_RDATA};
              end else begin
                ea_r <= {mhi_r, MEM_RDATA};
              end
              vec_r   <= 1'b0;
              bsel_r  <= 1'b0;
              state_r <= ST_IDLE;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes zero wait, reads one wait so data is fresh
  reg [31:0] rd_mux;

  always @* begin
    case (ahb_a_r)
      `CRA_OFF_ACCA:  rd_mux = {24'h000000, acc_a_r};
      `CRA_OFF_ACCB:  rd_mux = {24'h000000, acc_b_r};
      `CRA_OFF_ACCD:  rd_mux = {16'h0000, acc_d};
      `CRA_OFF_IX:    rd_mux = {16'h0000, ix_r};
      `CRA_OFF_IY:    rd_mux = {16'h0000, iy_r};
      `CRA_OFF_SP:    rd_mux = {16'h0000, sp_r};
      `CRA_OFF_PC:    rd_mux = {16'h0000, pc_r};
      `CRA_OFF_CCR:   rd_mux = {24'h000000, ccr_r};
      `CRA_OFF_QDATA: rd_mux = {{(31-QAW){1'b0}}, q_cnt};
      `CRA_OFF_CTRL:  rd_mux = {23'h000000, go_r, 1'b0, cond_r,
                                imm16_r, mode_r};
      `CRA_OFF_STAT:  rd_mux = {16'h0000, opc_r, len_r, 1'b0, taken_r,
                                stop_blk_r, !idle};
      `CRA_OFF_EA:    rd_mux = {16'h0000, ea_r};
      `CRA_OFF_OPND:  rd_mux = {16'h0000, opnd_r};
      default:        rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge CLK_SYS) begin
    if (RST) begin
      ahb_wr_r  <= 1'b0;
      ahb_rd_r  <= 1'b0;
      ahb_a_r   <= 8'h00;
      HRDATA    <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HRESP    <= 1'b0;
      ahb_wr_r <= 1'b0;
      if (ahb_rd_r) begin
        HRDATA    <= rd_mux;
        HREADYOUT <= 1'b1;
        ahb_rd_r  <= 1'b0;
      end else if (HSEL && HTRANS[1] && HREADY) begin
        ahb_a_r   <= (HADDR[31:8] == 24'h000000) ? HADDR[7:0] : 8'hFC;
        ahb_wr_r  <= HWRITE;
        ahb_rd_r  <= !HWRITE;
        HREADYOUT <= HWRITE;
      end
    end
  end
endmodule // cra_core

// File: src/cra_defs.vh
// Purpose: Constants of the register and addressing model
// Assumes: Byte addresses on a 32-bit AHB-Lite register bus
// Notes:   Definitions only
`ifndef CRA_DEFS_VH
`define CRA_DEFS_VH

`define CRA_OFF_ACCA   8'h00
`define CRA_OFF_ACCB   8'h04
`define CRA_OFF_ACCD   8'h08
`define CRA_OFF_IX     8'h0C
`define CRA_OFF_IY     8'h10
`define CRA_OFF_SP     8'h14
`define CRA_OFF_PC     8'h18
`define CRA_OFF_CCR    8'h1C
`define CRA_OFF_QDATA  8'h20
`define CRA_OFF_CTRL   8'h24
`define CRA_OFF_STAT   8'h28
`define CRA_OFF_EA     8'h2C
`define CRA_OFF_OPND   8'h30

`define CRA_CCR_S      7
`define CRA_CCR_X      6
`define CRA_CCR_H      5
`define CRA_CCR_I      4
`define CRA_CCR_N      3
`define CRA_CCR_Z      2
`define CRA_CCR_V      1
`define CRA_CCR_C      0
`define CRA_CCR_RST    8'hD0

`define CRA_MODE_INH   3'h0
`define CRA_MODE_IMM   3'h1
`define CRA_MODE_DIR   3'h2
`define CRA_MODE_EXT   3'h3
`define CRA_MODE_REL8  3'h4
`define CRA_MODE_REL16 3'h5
`define CRA_MODE_IDX   3'h6

`define CRA_CTRL_IMM16 3
`define CRA_CTRL_GO    8

`define CRA_PAGE2_PFX  8'h18
`define CRA_VEC_ADDR   16'hFFFE
`define CRA_STOP_OPC   8'h3E
`define CRA_MIN_QUEUE  4'h3

`endif

// File: src/cra_queue.v
// Purpose: Program byte queue storage with registered read data
// Assumes: Caller never pops when empty nor pushes when full
// Notes:   Read data valid the cycle after rd_en
`timescale 1ns/10ps
module cra_queue #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             wr_en,
  input  wire [WIDTH-1:0] wr_data,
  input  wire             rd_en,
  output reg  [WIDTH-1:0] rd_data,
  output reg  [AW:0]      count
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp_r;
  reg [AW-1:0]    rp_r;

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wp_r] <= wr_data;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wp_r    <= {AW{1'b0}};
      rp_r    <= {AW{1'b0}};
      count   <= {(AW+1){1'b0}};
      rd_data <= {WIDTH{1'b0}};
    end else begin
      if (wr_en) begin
        wp_r <= wp_r + 1'b1;
      end
      if (rd_en) begin
        rd_data <= mem[rp_r];
        rp_r    <= rp_r + 1'b1;
      end
      count <= count + {{AW{1'b0}}, wr_en} - {{AW{1'b0}}, rd_en};
    end
  end
endmodule // cra_queue

// File: verif/cra_core_assertions.sv
// Purpose: Port-level assertions for the register and address core
// Assumes: HREADY tied to HREADYOUT, one clock domain
// Notes:   Bound to cra_core after the module
`timescale 1ns/10ps
module cra_core_assertions #(
  parameter [15:0] RESET_VEC = 16'hFFFE
) (
  input wire        CLK_SYS,
  input wire        RST,
  input wire        HSEL,
  input wire [31:0] HADDR,
  input wire [1:0]  HTRANS,
  input wire        HWRITE,
  input wire [2:0]  HSIZE,
  input wire [31:0] HWDATA,
  input wire        HREADY,
  input wire [31:0] HRDATA,
  input wire        HREADYOUT,
  input wire        HRESP,
  input wire [15:0] MEM_ADDR,
  input wire        MEM_RD,
  input wire [7:0]  MEM_RDATA,
  input wire        MEM_ACK,
  input wire        STOP_REQ,
  input wire        BUSY
);
  wire       rd_take = HSEL & HTRANS[1] & HREADY & ~HWRITE;
  wire       wr_take = HSEL & HTRANS[1] & HREADY & HWRITE;
  reg        wr_ph_r;
  reg  [7:0] wr_off_r;
  reg        s_bit_r;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the stop-disable bit, taken from CONDITION_CODE_REGISTER write data phases
  always @(posedge CLK_SYS) begin
    if (RST) begin
      wr_ph_r  <= 1'b0;
      wr_off_r <= 8'h00;
      s_bit_r  <= 1'b1;
    end else begin
      wr_ph_r  <= wr_take & (HADDR[31:8] == 24'h000000);
      wr_off_r <= HADDR[7:0];
      if (wr_ph_r && wr_off_r == 8'h1C)
        s_bit_r <= HWDATA[7];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  chk_resp_okay: assert property (HRESP == 1'b0)
    else $error("HRESP not OKAY");
  chk_read_wait: assert property (rd_take |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (wr_take |=> HREADYOUT)
    else $error("write not zero wait");
  chk_mem_pulse: assert property (MEM_RD |=> !MEM_RD)
    else $error("MEM_RD longer than one cycle");
  chk_addr_stands: assert property ($changed(MEM_ADDR) |-> MEM_RD)
    else $error("MEM_ADDR moved without request");
  chk_vector_first: assert property ($fell(RST) |->
    ##[1:2] (MEM_RD && MEM_ADDR == RESET_VEC))
    else $error("vector fetch not at reset vector");
  chk_vector_order: assert property ($fell(RST) |->
    ##[3:40] (MEM_RD && MEM_ADDR == RESET_VEC + 16'h0001))
    else $error("vector low byte not at next address");
  chk_busy_done: assert property ($fell(RST) |-> ##[4:60] !BUSY)
    else $error("vector fetch did not finish");
  chk_stop_gate: assert property (STOP_REQ |-> !s_bit_r)
    else $error("stop issued while disabled");
  chk_stop_pulse: assert property (STOP_REQ |=> !STOP_REQ)
    else $error("STOP_REQ longer than one cycle");
endmodule // cra_core_assertions

bind cra_core cra_core_assertions #(.RESET_VEC(RESET_VEC)) u_cra_core_assertions (
  .CLK_SYS(CLK_SYS), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
  .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
  .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .STOP_REQ(STOP_REQ),
  .BUSY(BUSY));

// File: verif/cra_mem_model.sv
// Purpose: Byte memory answering the core's read requests
// Assumes: One outstanding read at a time
// Notes:   Latency alternates between short and long
`timescale 1ns/10ps
module cra_mem_model (
  input  wire        clk,
  input  wire        rst,
  input  wire [15:0] mem_addr,
  input  wire        mem_rd,
  output reg  [7:0]  mem_rdata,
  output reg         mem_ack
);
  reg        pend_r;
  reg        slow_r;
  reg [1:0]  wait_r;
  reg [15:0] addr_r;
  always @(posedge clk) begin
    mem_ack   <= 1'b0;
    // Data toggles outside the ack cycle so stale bytes are never reused
    mem_rdata <= ~mem_rdata;
    if (rst) begin
      pend_r    <= 1'b0;
      slow_r    <= 1'b0;
      wait_r    <= 2'h0;
      mem_rdata <= 8'hA5;
    end else if (pend_r) begin
      if (wait_r == 2'h0) begin
        mem_ack   <= 1'b1;
        mem_rdata <= addr_r[15:8] ^ addr_r[7:0] ^ 8'h5A;
        pend_r    <= 1'b0;
      end else begin
        wait_r <= wait_r - 2'h1;
      end
    end else if (mem_rd) begin
      pend_r <= 1'b1;
      addr_r <= mem_addr;
      wait_r <= slow_r ? 2'h2 : 2'h0;
      slow_r <= ~slow_r;
    end
  end
endmodule // cra_mem_model

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the register and address core
// Assumes: AHB-Lite single word transfers, memory model on far side
// Notes:   Instructions are fed through the queue register
`timescale 1ns/10ps
`include "cra_defs.vh"
module tb_top;
  reg         CLK_SYS;
  reg         RST;
  reg         HSEL;
  reg  [31:0] HADDR;
  reg  [1:0]  HTRANS;
  reg         HWRITE;
  reg  [31:0] HWDATA;
  wire [31:0] HRDATA;
  wire        HREADYOUT;
  wire        HRESP;
  wire [15:0] MEM_ADDR;
  wire        MEM_RD;
  wire [7:0]  MEM_RDATA;
  wire        MEM_ACK;
  wire        STOP_REQ;
  wire        BUSY;
  integer     num_errors;
  integer     total_checks;
  integer     cycles;
  integer     stop_seen;
  reg  [15:0] pc_exp;
  reg  [31:0] q;

  cra_core u_cra_core (.CLK_SYS(CLK_SYS), .RST(RST), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MEM_ADDR(MEM_ADDR),
    .MEM_RD(MEM_RD), .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK),
    .STOP_REQ(STOP_REQ), .BUSY(BUSY));
  cra_mem_model u_cra_mem_model (.clk(CLK_SYS), .rst(RST),
    .mem_addr(MEM_ADDR), .mem_rd(MEM_RD), .mem_rdata(MEM_RDATA),
    .mem_ack(MEM_ACK));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) begin
    cycles <= cycles + 1;
    if (STOP_REQ === 1'b1)
      stop_seen <= stop_seen + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function [7:0] mb(input [15:0] a);
    mb = a[15:8] ^ a[7:0] ^ 8'h5A;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Waits without limit; the cycle ceiling ends a hung transfer
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HADDR  <= a;
    HWRITE <= wr;
    @(posedge CLK_SYS);
    while (HREADYOUT !== 1'b1) begin
      @(posedge CLK_SYS);
    end
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge CLK_SYS);
    while (HREADYOUT !== 1'b1) begin
      @(posedge CLK_SYS);
    end
    r = HRDATA;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, {24'h0, a}, d, r);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    ahb(1'b0, a, 32'h0, r);
  endtask
  task automatic wait_idle();
    integer n;
    n = 0;
    repeat (2) @(posedge CLK_SYS);
    while (BUSY !== 1'b0 && n < 300) begin
      @(posedge CLK_SYS);
      n = n + 1;
    end
    check({31'h0, BUSY}, 32'h0, "busy stuck");
  endtask
  // Pushes nb bytes from the top of s, starts decode, checks length and PC
  task automatic run(input logic [7:0] ctl, input logic [31:0] s,
                     input integer nb, input logic [3:0] len,
                     input logic [15:0] pc_nxt);
    integer i;
    for (i = 0; i < nb; i = i + 1)
      wr(`CRA_OFF_QDATA, {24'h0, s[31-8*i -: 8]});
    wr(`CRA_OFF_CTRL, {23'h0, 1'b1, ctl});
    wait_idle();
    rd(`CRA_OFF_STAT, q);
    check(q[7:4], len, "length");
    rd(`CRA_OFF_PC, q);
    check(q, {16'h0, pc_nxt}, "next pc");
    pc_exp = pc_nxt;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    wait_idle();
    rd(`CRA_OFF_CCR, q);
    check(q, {24'h0, `CRA_CCR_RST}, "ccr reset");
    rd(`CRA_OFF_PC, q);
    check(q, {16'h0, mb(16'hFFFE), mb(16'hFFFF)}, "vector pc");
    pc_exp = {mb(16'hFFFE), mb(16'hFFFF)};
  endtask
  task automatic t_regs();
    wr(`CRA_OFF_ACCA, 32'h0000_0012);
    wr(`CRA_OFF_ACCB, 32'h0000_0034);
    wr(`CRA_OFF_IX, 32'h0000_0000);
    wr(`CRA_OFF_IY, 32'h0000_FFF0);
    wr(`CRA_OFF_SP, 32'h0000_8001);
    rd(`CRA_OFF_ACCD, q);
    check(q, 32'h0000_1234, "double acc");
    rd(`CRA_OFF_SP, q);
    check(q, 32'h0000_8001, "odd stack");
    rd(32'h0000_0100, q);
    check(q, 32'h0, "unmapped");
  endtask
  task automatic t_direct();
    run({5'h0, `CRA_MODE_DIR}, 32'h1896_C700, 3, 4'h3, pc_exp + 16'h3);
    rd(`CRA_OFF_EA, q);
    check(q, 32'h0000_00C7, "direct ea");
    rd(`CRA_OFF_STAT, q);
    check(q[15:8], 8'h96, "page two opcode");
  endtask
  task automatic t_idx5();
    run({5'h0, `CRA_MODE_IDX}, 32'h18A6_1F00, 3, 4'h3, pc_exp + 16'h3);
    rd(`CRA_OFF_EA, q);
    check(q, 32'h0000_FFFF, "x minus one");
  endtask
  task automatic t_ind16();
    run({5'h0, `CRA_MODE_IDX}, 32'hA6EB_0020, 4, 4'h4, pc_exp + 16'h4);
    rd(`CRA_OFF_EA, q);
    check(q, {16'h0, mb(16'h0010), mb(16'h0011)}, "wide ind");
  endtask
  task automatic t_indd();
    run({5'h0, `CRA_MODE_IDX}, 32'h18A6_F700, 3, 4'h3, pc_exp + 16'h3);
    rd(`CRA_OFF_EA, q);
    check(q, {16'h0, mb(16'h9235), mb(16'h9236)}, "d ind");
  endtask
  task automatic t_auto();
    run({5'h0, `CRA_MODE_IDX}, 32'h18A6_3100, 3, 4'h3, pc_exp + 16'h3);
    rd(`CRA_OFF_EA, q);
    check(q, 32'h0000_0000, "post inc ea");
    rd(`CRA_OFF_IX, q);
    check(q, 32'h0000_0002, "post inc x");
    run({5'h0, `CRA_MODE_IDX}, 32'hA6E9_1000, 3, 4'h3, pc_exp + 16'h3);
    rd(`CRA_OFF_EA, q);
    check(q, 32'h0000_FF00, "nine bit wrap");
  endtask
  task automatic t_imm();
    run({4'h0, 1'b1, `CRA_MODE_IMM}, 32'h86AB_CD00, 3, 4'h3,
        pc_exp + 16'h3);
    rd(`CRA_OFF_OPND, q);
    check(q, 32'h0000_ABCD, "imm16");
  endtask
  task automatic t_branch();
    run({5'h0, `CRA_MODE_REL8}, 32'h1820_8000, 3, 4'h3,
        pc_exp + 16'h3 - 16'h80);
    rd(`CRA_OFF_STAT, q);
    check(q[2], 1'b1, "taken");
    run({1'b0, 3'h1, 1'b0, `CRA_MODE_REL8}, 32'h1827_8000, 3, 4'h3,
        pc_exp + 16'h3);
    rd(`CRA_OFF_STAT, q);
    check(q[2], 1'b0, "not taken");
  endtask
  task automatic t_stop();
    run({5'h0, `CRA_MODE_INH}, 32'h183E_1800, 3, 4'h2, pc_exp + 16'h2);
    rd(`CRA_OFF_STAT, q);
    check(q[1], 1'b1, "stop blocked");
    check(stop_seen, 0, "stop pulse");
    wr(`CRA_OFF_CCR, 32'h0000_0050);
    run({5'h0, `CRA_MODE_INH}, 32'h3E01_0000, 2, 4'h2, pc_exp + 16'h2);
    check(stop_seen, 1, "stop issued");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    num_errors   = 0;
    total_checks = 0;
    cycles       = 0;
    stop_seen    = 0;
    RST    = 1'b1;
    HSEL   = 1'b0;
    HADDR  = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HWDATA = 32'h0;
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    t_reset();
    t_regs();
    t_direct();
    t_idx5();
    t_ind16();
    t_indd();
    t_auto();
    t_imm();
    t_branch();
    t_stop();
    print_verdict();
  end
endmodule // tb_top
